// File: src/ot_pkg.sv
// Package with register map, field layouts and constants for the overtravel supervisor.
package ot_pkg;
    // ========================================================================
    // Register byte addresses on the AHB-Lite bus.
    // ========================================================================
    // Indexed registers sit at four times their index, one word each.
    localparam logic [15:0] ADDR_WARN_SEL   = 16'h8034; // Warning select.
    localparam logic [15:0] ADDR_REL_SEL    = 16'h8088; // Release select.
    localparam logic [15:0] ADDR_DECEL_TIME = 16'h8c28; // Forced stop decel.
    localparam logic [15:0] ADDR_ESTOP_TRQ  = 16'h9018; // E-stop torque.
    localparam logic [15:0] ADDR_STOP_SEL   = 16'h2000; // Stop method select.
    localparam logic [15:0] ADDR_CONTROL    = 16'h2100; // Servo on, mode, clear.
    localparam logic [15:0] ADDR_STATUS     = 16'h2104; // Status word image.
    localparam logic [15:0] ADDR_DIGIN      = 16'h2108; // Digital inputs image.
    localparam logic [15:0] ADDR_MAXSPD     = 16'h210c; // Maximum motor speed.
    // Register indices as printed (kept for reference by software).
    localparam logic [15:0] IDX_WARN_SEL    = 16'h200d;
    localparam logic [15:0] IDX_REL_SEL     = 16'h2022;
    localparam logic [15:0] IDX_DECEL_TIME  = 16'h230a;
    localparam logic [15:0] IDX_ESTOP_TRQ   = 16'h2406;

    // ========================================================================
    // Reset values and field positions.
    // ========================================================================
    localparam logic [15:0] RST_ESTOP_TRQ   = 16'h0320; // 800 percent.
    localparam logic [15:0] RST_DECEL_TIME  = 16'h0000;
    localparam logic [15:0] MAX_ESTOP_TRQ   = 16'h0320; // Upper limit 800.
    localparam logic [15:0] MAX_DECEL_TIME  = 16'h2710; // Upper limit 10000.
    localparam logic [15:0] RST_MAXSPD      = 16'h1770; // Plain default.
    localparam int WARN_EN_BIT   = 12;  // Digit n.X000 of warning select.
    localparam int STOP_OT_LSB   = 4;   // Digit n.00X0 of stop select.
    localparam int SW_LIMIT_BIT  = 11;  // Internal limit active.
    localparam int SW_HOMERR_BIT = 13;  // Homing error.
    localparam int SW_TREACH_BIT = 10;  // Target reached.
    localparam int DI_REV_BIT    = 0;
    localparam int DI_FWD_BIT    = 1;
    localparam logic [3:0] STOP_TRQ_ZC   = 4'h1;
    localparam logic [3:0] STOP_TRQ_CST  = 4'h2;
    localparam logic [3:0] STOP_DEC_ZC   = 4'h3;
    localparam logic [3:0] STOP_DEC_CST  = 4'h4;

    // ========================================================================
    // Timing: one millisecond tick at the system clock rate.
    // ========================================================================
    localparam int CLK_HZ      = 25000000;
    localparam int TICK_MS_US  = 1000;
    localparam int MS_CYCLES   = CLK_HZ / 1000000 * TICK_MS_US;

    // Operating modes as set by the host.
    typedef enum logic [2:0] {
        MODE_PP, MODE_HM, MODE_IP, MODE_CSP, MODE_PV, MODE_CSV, MODE_PT,
        MODE_CST
    } op_mode_t;

    // Stop actions presented to the drive stage.
    typedef enum logic [1:0] {
        ACT_RUN, ACT_DECEL, ACT_ZCLAMP, ACT_COAST
    } stop_act_t;

    // Reference carried from the host as one bundle.
    typedef struct packed {
        logic        valid;   // A reference is present.
        logic        dir_neg; // Reference points in reverse.
        logic [15:0] magnitude;
    } reference_t;
endpackage

// File: src/overtravel_supervisor.sv
// Overtravel supervisor for one servo axis with an AHB-Lite register slave.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - Stop codes 1,2 decelerate with torque ceiling; code in force stays 0 (coast)
// - Stop torque 0..800 percent, default 800
// - Decel time 0..10000 ms, default 0
// - Zero decel time commands zero speed
// - Decel time scaled from maximum speed
// - Warning select bit enables detection
// - Warning only while servo is on
// - Warning latched even for short pulses
// - Warning neither stops nor blocks commands
// - Warning only in reference direction; with no reference, either direction
// - Servo-on during overtravel raises nothing
// - Clear command clears the warning unless an onset coincides
// - After clear, wait until overtravel left
// - Warning detected despite software limit
// - Release method chooses overtravel definition; method in force stays 0
// - No drive toward overtravel direction
// - Status bit 11 follows overtravel
// - Digital inputs bits show limit inputs
// - Position modes cancel target, reset reached
// - Forward limit aborts listed homing methods
// - Reverse limit aborts listed homing methods
// - Velocity modes run only away
// - Torque modes apply torque only away
// - Limit input low means prohibited
// - Stop code 1 holds zero clamp; code in force stays 0 (coast)
// - Torque control stops by coasting
module overtravel_supervisor (
    input  wire logic                  CLK_I,           // 25 MHz clock.
    input  wire logic                  RST_I,           // Async reset, high.
    // AHB-Lite slave.
    input  wire logic                  HSEL_I,
    input  wire logic [31:0]           HADDR_I,
    input  wire logic [1:0]            HTRANS_I,
    input  wire logic                  HWRITE_I,
    input  wire logic [2:0]            HSIZE_I,
    input  wire logic [31:0]           HWDATA_I,
    input  wire logic                  HREADY_I,
    output logic      [31:0]           HRDATA_O,
    output logic                       HREADYOUT_O,
    output logic                       HRESP_O,
    // Limit switches and axis state.
    input  wire logic                  FWD_PROHIBIT_N_I, // Low = prohibited.
    input  wire logic                  REV_PROHIBIT_N_I, // Low = prohibited.
    input  wire logic                  BEYOND_FWD_I,     // Past fwd switch.
    input  wire logic                  BEYOND_REV_I,     // Past rev switch.
    input  wire logic                  SW_LIMIT_I,       // Software limit hit.
    input  wire logic                  MOTOR_STOPPED_I,  // Speed is zero.
    input  wire ot_pkg::reference_t    REF_I,            // Host reference.
    input  wire logic [5:0]            HOMING_METHOD_I,
    // Drive stage outputs.
    output ot_pkg::stop_act_t          STOP_ACT_O,
    output logic      [15:0]           TORQUE_CEIL_O,    // Percent rated.
    output logic      [15:0]           DECEL_STEP_O,     // Speed per ms.
    output logic                       DRIVE_ALLOW_O,    // Reference passes.
    output logic                       CANCEL_TARGET_O,  // Pulse.
    output logic                       WARNING_O         // Overtravel warning.
);
    // ========================================================================
    // Register storage.
    // ========================================================================
    logic [15:0]      warn_sel;      // Overtravel warning select.
    logic [15:0]      release_sel;   // Overtravel release select.
    logic [15:0]      decel_time;    // Forced stop decel time, ms.
    logic [15:0]      estop_torque;  // Emergency stop torque, percent.
    logic [15:0]      stop_sel;      // Stop method select.
    logic [15:0]      max_speed;     // Maximum motor speed.
    logic             servo_on;      // Control bit 0.
    ot_pkg::op_mode_t mode;          // Control bits 6:4.
    logic             clear_pulse;   // Control bit 8 written high.
    logic             fault_reset;   // Control bit 9 written high.
    logic [15:0]      status_word;   // Status word image.
    logic [15:0]      dig_inputs;    // Digital inputs image.
    // Settings latched at reset release.
    logic             armed;         // Restart sample taken.
    logic             rel_beyond;    // Release method 1 in force.
    logic [3:0]       ot_stop_code;  // Overtravel stop code in force.

    // Clip a written value to its legal upper bound.
    function automatic logic [15:0] clip(input logic [15:0] v,
                                         input logic [15:0] hi);
        clip = (v > hi) ? hi : v;
    endfunction

    // ========================================================================
    // AHB-Lite address phase capture; the slave never waits.
    // ========================================================================
    logic        wr_pend;            // Data phase of a write pending.
    logic [15:0] wr_addr;            // Its address.
    wire         take = HSEL_I && HREADY_I && HTRANS_I[1];

    assign HREADYOUT_O = 1'b1;       // Zero wait states.
    assign HRESP_O     = 1'b0;       // Always OKAY.

    // Latch the address phase so the data phase can use it.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend  <= 1'b0;
            wr_addr  <= 16'h0000;
        end else begin
            wr_pend  <= take && HWRITE_I;
            wr_addr  <= HADDR_I[15:0];
        end
    end

    // Register writes; values beyond range are clipped; all but the stop and release selects take effect at once.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            warn_sel     <= 16'h0000;
            release_sel  <= 16'h0000;
            decel_time   <= ot_pkg::RST_DECEL_TIME;
            estop_torque <= ot_pkg::RST_ESTOP_TRQ;
            stop_sel     <= 16'h0000;
            max_speed    <= ot_pkg::RST_MAXSPD;
            servo_on     <= 1'b0;
            mode         <= ot_pkg::MODE_PP;
            clear_pulse  <= 1'b0;
            fault_reset  <= 1'b0;
        end else begin
            clear_pulse <= 1'b0;
            fault_reset <= 1'b0;
            if (wr_pend) begin
                case (wr_addr)
                    ot_pkg::ADDR_WARN_SEL:   warn_sel <= HWDATA_I[15:0];
                    ot_pkg::ADDR_REL_SEL:    release_sel <= HWDATA_I[15:0];
                    ot_pkg::ADDR_DECEL_TIME: decel_time <=
                        clip(HWDATA_I[15:0], ot_pkg::MAX_DECEL_TIME);
                    ot_pkg::ADDR_ESTOP_TRQ:  estop_torque <=
                        clip(HWDATA_I[15:0], ot_pkg::MAX_ESTOP_TRQ);
                    ot_pkg::ADDR_STOP_SEL:   stop_sel <= HWDATA_I[15:0];
                    ot_pkg::ADDR_MAXSPD:     max_speed <= HWDATA_I[15:0];
                    ot_pkg::ADDR_CONTROL: begin
                        servo_on    <= HWDATA_I[0];
                        mode        <= ot_pkg::op_mode_t'(HWDATA_I[6:4]);
                        clear_pulse <= HWDATA_I[8];
                        fault_reset <= HWDATA_I[9];
                    end
                    default: ;  // Unmapped writes are dropped.
                endcase
            end
        end
    end

    // Read data; unmapped addresses read zero.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (take && !HWRITE_I) begin
            case (HADDR_I[15:0])
                ot_pkg::ADDR_WARN_SEL:   HRDATA_O <= {16'h0000, warn_sel};
                ot_pkg::ADDR_REL_SEL:    HRDATA_O <= {16'h0000, release_sel};
                ot_pkg::ADDR_DECEL_TIME: HRDATA_O <= {16'h0000, decel_time};
                ot_pkg::ADDR_ESTOP_TRQ:  HRDATA_O <= {16'h0000, estop_torque};
                ot_pkg::ADDR_STOP_SEL:   HRDATA_O <= {16'h0000, stop_sel};
                ot_pkg::ADDR_MAXSPD:     HRDATA_O <= {16'h0000, max_speed};
                ot_pkg::ADDR_CONTROL:    HRDATA_O <= {25'h0000000,
                                             mode, 3'h0, servo_on};
                ot_pkg::ADDR_STATUS:     HRDATA_O <= {16'h0000, status_word};
                ot_pkg::ADDR_DIGIN:      HRDATA_O <= {16'h0000, dig_inputs};
                default:                 HRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    // ========================================================================
    // Settings sampled once after reset, so only their reset values apply.
    // ========================================================================
    // Sampled in the first clocked cycle after reset; never reloaded later,
    // and reset also zeroes these fields, so a write to them never matters.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            armed        <= 1'b0;
            rel_beyond   <= 1'b0;
            ot_stop_code <= 4'h0;
        end else if (!armed) begin
            armed        <= 1'b1;
            rel_beyond   <= release_sel[0];
            ot_stop_code <= stop_sel[ot_pkg::STOP_OT_LSB +: 4];
        end
    end

    // ========================================================================
    // Overtravel detection.
    // ========================================================================
    wire fwd_in = !FWD_PROHIBIT_N_I;
    wire rev_in = !REV_PROHIBIT_N_I;
    // Method 1 also needs the position beyond the switch.
    wire fwd_ot = fwd_in && (!rel_beyond || BEYOND_FWD_I);
    wire rev_ot = rev_in && (!rel_beyond || BEYOND_REV_I);
    wire any_ot = fwd_ot || rev_ot;
    // Overtravel in the reference's own direction blocks driving.
    wire same_dir_ot = REF_I.valid &&
        (REF_I.dir_neg ? rev_ot : fwd_ot);
    wire torque_mode = (mode == ot_pkg::MODE_PT) ||
                       (mode == ot_pkg::MODE_CST);
    wire pos_mode = (mode == ot_pkg::MODE_PP) || (mode == ot_pkg::MODE_IP) ||
                    (mode == ot_pkg::MODE_CSP);

    // ========================================================================
    // Warning latch.
    // ========================================================================
    logic warn_dir_hit;   // Overtravel in a direction that counts.
    logic servo_prev;     // Servo state one cycle ago.
    logic ot_prev;        // Qualifying overtravel one cycle ago.
    logic suppress;       // Redetection held off after fault reset.

    // Only the reference direction counts; with no reference both do.
    always_comb begin
        if (!REF_I.valid) begin
            warn_dir_hit = any_ot;
        end else begin
            warn_dir_hit = REF_I.dir_neg ? rev_ot : fwd_ot;
        end
    end

    // The warning is raised on the onset of overtravel while servo is on,
    // so switching on into existing overtravel raises nothing.
    wire warn_onset = warn_sel[ot_pkg::WARN_EN_BIT] && servo_on &&
        servo_prev && warn_dir_hit && !ot_prev && !suppress;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            servo_prev <= 1'b0;
            ot_prev    <= 1'b0;
        end else begin
            servo_prev <= servo_on;
            // Overtravel seen while the servo was off counts as existing.
            ot_prev    <= warn_dir_hit;
        end
    end

    // Suppress after a fault reset during overtravel until it is left.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            suppress <= 1'b0;
        end else if (fault_reset && any_ot) begin
            suppress <= 1'b1;
        end else if (!any_ot) begin
            suppress <= 1'b0;
        end
    end

    // Sticky warning; it feeds only the status path, never the stop logic.
    // A fresh onset wins over a clear in the same cycle. A software limit
    // plays no part here, so detection continues alongside it.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            WARNING_O <= 1'b0;
        end else if (warn_onset) begin
            WARNING_O <= 1'b1;
        end else if (clear_pulse || fault_reset) begin
            WARNING_O <= 1'b0;
        end
    end

    // ========================================================================
    // Stop action, torque ceiling and deceleration step.
    // ========================================================================
    // Step per millisecond so that full speed reaches zero in decel_time.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DECEL_STEP_O <= 16'h0000;
        end else if (decel_time == 16'h0000) begin
            DECEL_STEP_O <= max_speed;              // immediate zero
        end else begin
            DECEL_STEP_O <= max_speed / decel_time;
        end
    end

    // Emergency stop torque, effective immediately; the drive stage
    // further caps it by the motor maximum torque.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TORQUE_CEIL_O <= ot_pkg::RST_ESTOP_TRQ;
        end else begin
            TORQUE_CEIL_O <= estop_torque;
        end
    end

    // Choose the stop action while overtravel blocks the reference. The
    // warning is not an input here, so it never stops the motor.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            STOP_ACT_O <= ot_pkg::ACT_RUN;
        end else if (!same_dir_ot) begin
            STOP_ACT_O <= ot_pkg::ACT_RUN;
        end else if (torque_mode) begin
            STOP_ACT_O <= ot_pkg::ACT_COAST;
        end else begin
            case (ot_stop_code)
                ot_pkg::STOP_TRQ_ZC, ot_pkg::STOP_DEC_ZC:
                    STOP_ACT_O <= MOTOR_STOPPED_I ? ot_pkg::ACT_ZCLAMP
                                  : ot_pkg::ACT_DECEL;
                ot_pkg::STOP_TRQ_CST, ot_pkg::STOP_DEC_CST:
                    STOP_ACT_O <= MOTOR_STOPPED_I ? ot_pkg::ACT_COAST
                                  : ot_pkg::ACT_DECEL;
                default:
                    STOP_ACT_O <= ot_pkg::ACT_COAST;
            endcase
        end
    end

    // Motion toward the limit is never passed; away is allowed while servo is on.
    // Covers position return moves, velocity and torque commands alike.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DRIVE_ALLOW_O <= 1'b0;
        end else begin
            DRIVE_ALLOW_O <= servo_on && REF_I.valid &&
                !same_dir_ot;
        end
    end

    // ========================================================================
    // Target cancel pulse and status word.
    // ========================================================================
    logic ot_seen;        // Overtravel one cycle ago; target cancelled in position modes only.
    wire  ot_rise = any_ot && !ot_seen;

    // One-cycle cancel on overtravel onset in position modes.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ot_seen         <= 1'b0;
            CANCEL_TARGET_O <= 1'b0;
        end else begin
            ot_seen         <= any_ot;
            CANCEL_TARGET_O <= ot_rise && pos_mode;
        end
    end

    // Homing methods that abort on one limit or the other.
    function automatic logic fwd_abort_method(input logic [5:0] m);
        case (m)
            6'h01, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h1c, 6'h22:
                fwd_abort_method = 1'b1;
            default: fwd_abort_method = 1'b0;
        endcase
    endfunction
    function automatic logic rev_abort_method(input logic [5:0] m);
        case (m)
            6'h02, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h18, 6'h21:
                rev_abort_method = 1'b1;
            default: rev_abort_method = 1'b0;
        endcase
    endfunction

    wire homing = (mode == ot_pkg::MODE_HM);
    wire hom_err = homing &&
        ((fwd_in && fwd_abort_method(HOMING_METHOD_I)) ||
         (rev_in && rev_abort_method(HOMING_METHOD_I)));

    // Status word: limit bit follows overtravel, homing error is sticky
    // until the mode changes away, target reached drops after an overtravel stop in position modes.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            status_word <= 16'h0000;
        end else begin
            status_word[ot_pkg::SW_LIMIT_BIT] <= any_ot;
            if (hom_err) begin
                status_word[ot_pkg::SW_HOMERR_BIT] <= 1'b1;
            end else if (!homing) begin
                status_word[ot_pkg::SW_HOMERR_BIT] <= 1'b0;
            end
            if (any_ot && pos_mode && MOTOR_STOPPED_I) begin
                status_word[ot_pkg::SW_TREACH_BIT] <= 1'b0;
            end else if (!any_ot && pos_mode && MOTOR_STOPPED_I) begin
                status_word[ot_pkg::SW_TREACH_BIT] <= !REF_I.valid;
            end
            status_word[0] <= WARNING_O;   // Warning present.
            status_word[1] <= SW_LIMIT_I;  // Software limit seen.
        end
    end

    // Digital inputs follow the raw limit inputs.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dig_inputs <= 16'h0000;
        end else begin
            dig_inputs <= 16'h0000;
            dig_inputs[ot_pkg::DI_REV_BIT] <= rev_in;
            dig_inputs[ot_pkg::DI_FWD_BIT] <= fwd_in;
        end
    end

endmodule // overtravel_supervisor

// File: verif/ot_host_model.sv
// Host motion controller model that issues the axis reference.
`timescale 1ns/100ps
// ============================================================
// Reference source, updated only after a rising clock edge.
module ot_host_model (
    input  wire logic       clk,     // Supervisor clock.
    input  wire logic       go,      // A reference is wanted.
    input  wire logic       neg,     // Reference points in reverse.
    output ot_pkg::reference_t ref_o // Bundle seen by the device.
);
    // The magnitude toggles while idle so a stale value never looks valid.
    always_ff @(posedge clk) begin
        ref_o <= {go, neg, go ? 16'h0100 : ~ref_o.magnitude};
    end
endmodule // ot_host_model

// File: verif/overtravel_supervisor_asserts.sv
// Concurrent checks on the overtravel supervisor ports.
`timescale 1ns/100ps
// ============================================================
// Checker module; it only watches, it never drives.
module ot_sup_chk (
    input wire logic               CLK_I,
    input wire logic               RST_I,
    input wire logic               HSEL_I,
    input wire logic               HREADYOUT_O,
    input wire logic               HRESP_O,
    input wire logic               FWD_PROHIBIT_N_I,
    input wire logic               REV_PROHIBIT_N_I,
    input wire ot_pkg::reference_t REF_I,
    input wire logic [15:0]        TORQUE_CEIL_O,
    input wire logic               DRIVE_ALLOW_O,
    input wire logic               CANCEL_TARGET_O,
    input wire logic               WARNING_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic hit;   // A limit is active toward the reference or no reference.
    logic fblk;  // Forward reference runs into an active forward limit.
    logic rblk;  // Reverse reference runs into an active reverse limit.
    assign hit = (!FWD_PROHIBIT_N_I && !(REF_I.valid && REF_I.dir_neg))
        || (!REV_PROHIBIT_N_I && !(REF_I.valid && !REF_I.dir_neg));
    assign fblk = !FWD_PROHIBIT_N_I && REF_I.valid && !REF_I.dir_neg;
    assign rblk = !REV_PROHIBIT_N_I && REF_I.valid && REF_I.dir_neg;
    torque_cap_a: assert property (TORQUE_CEIL_O <= 16'h0320)
        else $error("torque ceiling above 800");
    torque_dflt_a: assert property ($fell(RST_I) |->
        TORQUE_CEIL_O == 16'h0320) else $error("torque ceiling default");
    fwd_block_a: assert property ($past(fblk) && $past(fblk, 2)
        |-> !DRIVE_ALLOW_O) else $error("drive toward forward limit");
    rev_block_a: assert property ($past(rblk) && $past(rblk, 2)
        |-> !DRIVE_ALLOW_O) else $error("drive toward reverse limit");
    warn_dir_a: assert property ($rose(WARNING_O) |-> $past(hit)
        || $past(hit, 2) || $past(hit, 3)) else $error("warning cause");
    warn_hold_a: assert property ($past(WARNING_O) && !$past(HSEL_I)
        && !$past(HSEL_I, 2) && !$past(HSEL_I, 3) && !$past(HSEL_I, 4)
        |-> WARNING_O) else $error("warning dropped by itself");
    cancel_pulse_a: assert property (CANCEL_TARGET_O |=>
        !CANCEL_TARGET_O) else $error("cancel longer than a pulse");
    bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus answer not ready okay");
endmodule // ot_sup_chk
bind overtravel_supervisor ot_sup_chk ot_sup_chk_i (.*);

// File: verif/tb_overtravel_supervisor.sv
// Self-checking bench for the overtravel supervisor.
`timescale 1ns/100ps
module tb_overtravel_supervisor;
    logic CLK_I = 0, RST_I = 1, HSEL_I = 0, HWRITE_I = 0, go = 0, neg = 0;
    logic FWD_N = 1, REV_N = 1, SWL = 0;
    logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O, rd;
    logic [1:0] HTRANS_I = 0;
    logic [15:0] trq, step;
    logic rdy, resp, allow, cancel, warn;
    ot_pkg::reference_t ref_w;
    ot_pkg::stop_act_t act;
    int bad_count = 0, cmp_count = 0;
    always #20 CLK_I = ~CLK_I;
    ot_host_model ot_host_model_i (.clk(CLK_I), .go(go), .neg(neg),
        .ref_o(ref_w));
    overtravel_supervisor overtravel_supervisor_i (.CLK_I(CLK_I),
        .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2),
        .HWDATA_I(HWDATA_I), .HREADY_I(rdy), .HRDATA_O(HRDATA_O),
        .HREADYOUT_O(rdy), .HRESP_O(resp), .FWD_PROHIBIT_N_I(FWD_N),
        .REV_PROHIBIT_N_I(REV_N), .BEYOND_FWD_I(1'h0), .BEYOND_REV_I(1'h0),
        .SW_LIMIT_I(SWL), .MOTOR_STOPPED_I(1'h1), .REF_I(ref_w),
        .HOMING_METHOD_I(6'h00), .STOP_ACT_O(act), .TORQUE_CEIL_O(trq),
        .DECEL_STEP_O(step), .DRIVE_ALLOW_O(allow),
        .CANCEL_TARGET_O(cancel), .WARNING_O(warn));
    // One single AHB-Lite word transfer; read data taken at its last edge.
    task automatic bus(input logic w, input logic [15:0] a,
            input logic [31:0] d);
        HSEL_I <= 1; HTRANS_I <= 2'h2; HWRITE_I <= w; HADDR_I <= {16'h0, a};
        do @(posedge CLK_I); while (rdy !== 1'b1);
        HSEL_I <= 0; HTRANS_I <= 2'h0; HWDATA_I <= d;
        do @(posedge CLK_I); while (rdy !== 1'b1);
        rd = HRDATA_O;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Register defaults, clipping, immediate effect and an unmapped read.
    task automatic t_regs();
        bus(0, ot_pkg::ADDR_ESTOP_TRQ, 0); chk(rd, 32'h320);
        bus(0, ot_pkg::ADDR_DECEL_TIME, 0); chk(rd, 32'h0);
        bus(1, ot_pkg::ADDR_ESTOP_TRQ, 32'h384); bus(0, ot_pkg::ADDR_ESTOP_TRQ, 0);
        chk(rd, 32'h320);
        // Outputs are registered one edge after the write has landed.
        bus(1, ot_pkg::ADDR_ESTOP_TRQ, 32'h123); repeat (2) @(posedge CLK_I);
        chk(trq, 16'h0123);
        chk(step, 16'h1770);
        bus(1, ot_pkg::ADDR_DECEL_TIME, 32'h0a); repeat (2) @(posedge CLK_I);
        chk(step, 16'h0258);
        bus(1, ot_pkg::ADDR_DECEL_TIME, 32'h4e20); bus(0, ot_pkg::ADDR_DECEL_TIME, 0);
        chk(rd, 32'h2710);
        bus(0, 16'h2ffc, 0); chk(rd, 32'h0);
    endtask
    // Limit inputs seen in the digital inputs and status images.
    task automatic t_limits();
        REV_N <= 0; repeat (2) @(posedge CLK_I);
        chk(cancel, 1'b1); @(posedge CLK_I);
        chk(cancel, 1'b0);
        bus(0, ot_pkg::ADDR_DIGIN, 0); chk(rd[1:0], 2'h1);
        bus(0, ot_pkg::ADDR_STATUS, 0); chk(rd[11], 1'b1);
        REV_N <= 1; repeat (3) @(posedge CLK_I);
        bus(0, ot_pkg::ADDR_STATUS, 0); chk(rd[11], 1'b0);
    endtask
    // Momentary forward limit with a forward reference, then a clear.
    task automatic t_warn();
        // Reference and servo settle first, so only direction decides.
        go <= 1; bus(1, ot_pkg::ADDR_WARN_SEL, 32'h1000);
        bus(1, ot_pkg::ADDR_CONTROL, 1); @(posedge CLK_I);
        SWL <= 1; REV_N <= 0; repeat (4) @(posedge CLK_I);
        chk(warn, 1'b0); chk(allow, 1'b1); REV_N <= 1;
        chk(act, ot_pkg::ACT_RUN);
        @(posedge CLK_I); FWD_N <= 0; repeat (2) @(posedge CLK_I);
        FWD_N <= 1; chk(allow, 1'b0);
        repeat (4) @(posedge CLK_I); chk(warn, 1'b1);
        bus(1, ot_pkg::ADDR_CONTROL, 32'h101); repeat (3) @(posedge CLK_I);
        chk(warn, 1'b0); go <= 0;
    endtask
    initial begin
        repeat (4) @(posedge CLK_I);
        RST_I <= 0; @(posedge CLK_I);
        t_regs(); t_limits(); t_warn(); report_and_stop();
    end
    initial begin
        #200000; bad_count++; report_and_stop();
    end
endmodule // tb_overtravel_supervisor
